// File: core/core_pc_stack_status.sv
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
// Function
// RL1: time-out flag set on clear/sleep, cleared by timeout
// RL2: power-down flag set on clear, cleared by sleep
// RL3: zero flag follows result equal zero
// RL4: digit carry from bit three, inverted borrow
// RL5: carry from msb, inverted borrow, rotate out
// RL6: status destination cannot override affected flags
// RL7: program counter increments every instruction
// RL8: jump loads counter bits eight to zero
// RL9: counter bit nine comes from page select
// RL10: counter low byte readable and writable
// RL11: call or low-byte write clears bit eight
// RL12: reset points counter at last location
// RL13: counter wraps from last location to zero
// RL14: reset clears the page select bit
// RL15: two-level stack of twelve-bit entries
// RL16: call pushes level one down, stores pc+1
// RL17: return pops level one, copies level two
// RL18: level two never cleared by return
// RL19: return loads working register with literal
// RL20: no stack overflow or underflow indication
module core_pc_stack_status
  import core_pc_stack_status_pkg::*;
(
  input  wire logic              CLK_I,
  input  wire logic              RESET_I,
  input  wire logic              EXEC_I,
  input  wire exec_s             INSTR_I,
  input  wire logic              WDT_TIMEOUT_I,
  output logic [PC_W-1:0]        PC_O,
  output logic [7:0]             STATUS_O,
  output byte_s                  RESULT_O,
  output byte_s                  W_LOAD_O,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR
);

  function automatic alu_out_s alu_eval(input alu_e       kind,
                                        input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic [7:0] lres,
                                        input logic       cin);
    logic [8:0] sum;
    logic [4:0] nib;
    alu_out_s   o;
    sum = 9'h000;
    nib = 5'h00;
    o   = '0;
    unique case (kind)
      ALU_ADD: begin
        sum  = {1'b0, a} + {1'b0, b};
        nib  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        o.res = sum[7:0];
        o.c   = sum[8];                                   // [RL5]
        o.dc  = nib[4];                                   // [RL4]
      end
      ALU_SUB: begin
        o.res = a - b;
        o.c   = (a >= b);                                 // [RL5]
        o.dc  = (a[3:0] >= b[3:0]);                       // [RL4]
      end
      ALU_RRF: begin
        o.res = {cin, a[7:1]};
        o.c   = a[0];                                     // [RL5]
      end
      ALU_RLF: begin
        o.res = {a[6:0], cin};
        o.c   = a[7];                                     // [RL5]
      end
      ALU_LOGIC: o.res = lres;
      ALU_MOVE:  o.res = a;
      // idle words between instructions may carry unused kind codes
      default:   o.res = a;
    endcase
    o.z = (o.res == 8'h00);                               // [RL3]
    return o;
  endfunction : alu_eval

  // mask order is {z, dc, c}
  function automatic logic [2:0] flag_mask(input alu_e kind);
    unique case (kind)
      ALU_ADD, ALU_SUB: return 3'h7;
      ALU_RRF, ALU_RLF: return 3'h1;
      ALU_LOGIC:        return 3'h4;
      ALU_MOVE:         return 3'h0;
      default:          return 3'h0;
    endcase
  endfunction : flag_mask

  logic [PC_W-1:0]  pc_ff;
  logic [PC_W-1:0]  nxt_pc;
  logic [STK_W-1:0] stk_ff [2];
  logic             wake_ff;
  logic             page_ff;
  logic             to_ff;
  logic             pd_ff;
  logic             z_ff;
  logic             dc_ff;
  logic             c_ff;
  logic [31:0]      rdata_ff;
  byte_s            result_ff;
  byte_s            wload_ff;

  alu_out_s         alu;
  logic [2:0]       mask;
  logic             is_alu;
  logic             core_st_wr;
  logic             core_pcl_wr;
  logic             apb_access;
  logic             apb_wr;
  logic             apb_st_wr;
  logic             apb_pcl_wr;
  logic             mapped;
  logic [PC_W-1:0]  pc_inc;

  assign alu    = alu_eval(INSTR_I.alu, INSTR_I.opa, INSTR_I.opb,
                           INSTR_I.logic_res, c_ff);
  assign is_alu = EXEC_I && (INSTR_I.op == OP_ALU);
  assign mask   = is_alu ? flag_mask(INSTR_I.alu) : 3'h0;
  assign core_st_wr  = is_alu && INSTR_I.dest_status;
  assign core_pcl_wr = is_alu && INSTR_I.dest_pcl;
  // wraps from the reset vector to zero after the calibration instruction
  assign pc_inc = pc_ff + 10'h001;                         // [RL7] [RL13]

  // bus side: writes wait for as long as the core executes, so the
  // instruction stream always wins a collision without losing the write
  assign apb_access = PSEL && PENABLE;
  assign PREADY     = !(PWRITE && EXEC_I);
  assign apb_wr     = apb_access && PWRITE && PREADY;
  assign apb_st_wr  = apb_wr && (PADDR == ADR_STATUS);
  assign apb_pcl_wr = apb_wr && (PADDR == ADR_PCL);         // [RL10]
  assign mapped = (PADDR == ADR_STATUS) || (PADDR == ADR_PCL) ||
                  (PADDR == ADR_PC) || (PADDR == ADR_STK1) ||
                  (PADDR == ADR_STK2);
  assign PSLVERR = apb_access && PREADY &&
                   (!mapped || (PWRITE && PADDR != ADR_STATUS &&
                                PADDR != ADR_PCL));
  assign PRDATA  = rdata_ff;

  always_comb begin
    nxt_pc = pc_ff;
    if (EXEC_I) begin
      unique case (INSTR_I.op)
        OP_JUMP:  nxt_pc = {page_ff, INSTR_I.target};        // [RL8] [RL9]
        OP_CALL:  nxt_pc = {page_ff, 1'b0, INSTR_I.lit};     // [RL11]
        OP_RETURN_LITERAL_INSTR: nxt_pc = stk_ff[0][PC_W-1:0];              // [RL17]
        default: begin
          if (core_pcl_wr) begin
            nxt_pc = {page_ff, 1'b0, alu.res};               // [RL11]
          end else begin
            nxt_pc = pc_inc;                                 // [RL7]
          end
        end
      endcase
    end else if (apb_pcl_wr) begin
      nxt_pc = {page_ff, 1'b0, PWDATA[7:0]};                 // [RL10] [RL11]
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      pc_ff <= PC_RESET_VEC;                                 // [RL12]
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // no depth tracking exists, so over- and underflow are silent
  always_ff @(posedge CLK_I) begin                           // [RL15] [RL20]
    if (RESET_I) begin
      stk_ff[0] <= STK_RESET;
      stk_ff[1] <= STK_RESET;
    end else if (EXEC_I && INSTR_I.op == OP_CALL) begin
      stk_ff[1] <= stk_ff[0];                                // [RL16]
      stk_ff[0] <= STK_W'(pc_inc);                           // [RL16]
    end else if (EXEC_I && INSTR_I.op == OP_RETURN_LITERAL_INSTR) begin
      stk_ff[0] <= stk_ff[1];                                // [RL17] [RL18]
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      wload_ff <= '0;
    end else begin
      wload_ff.valid <= EXEC_I && (INSTR_I.op == OP_RETURN_LITERAL_INSTR);  // [RL19]
      wload_ff.data  <= INSTR_I.lit;                         // [RL19]
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      result_ff <= '0;
    end else begin
      result_ff.valid <= is_alu;
      result_ff.data  <= alu.res;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      wake_ff <= ST_WAKE_RST;
      page_ff <= ST_PAGE_RST;                                // [RL14]
    end else if (core_st_wr) begin
      wake_ff <= alu.res[ST_WAKE];
      page_ff <= alu.res[ST_PAGE];                           // [RL9]
    end else if (apb_st_wr) begin
      wake_ff <= PWDATA[ST_WAKE];
      page_ff <= PWDATA[ST_PAGE];
    end
  end

  // set by clear/sleep wins over a timeout in the same cycle
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      to_ff <= ST_TO_RST;
    end else if (EXEC_I && (INSTR_I.op == OP_WDTCLR || INSTR_I.op == OP_SLEEP)) begin
      to_ff <= 1'b1;                                         // [RL1]
    end else if (WDT_TIMEOUT_I) begin
      to_ff <= 1'b0;                                         // [RL1]
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      pd_ff <= ST_PD_RST;
    end else if (EXEC_I && INSTR_I.op == OP_WDTCLR) begin
      pd_ff <= 1'b1;                                         // [RL2]
    end else if (EXEC_I && INSTR_I.op == OP_SLEEP) begin
      pd_ff <= 1'b0;                                         // [RL2]
    end
  end

  // an affected flag always takes the operation's value, even when the
  // status register is the destination, so a write there may not stick
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      z_ff  <= ST_ALU_RST;
      dc_ff <= ST_ALU_RST;
      c_ff  <= ST_ALU_RST;
    end else begin
      if (mask[2]) begin
        z_ff <= alu.z;                                       // [RL3] [RL6]
      end else if (core_st_wr) begin
        z_ff <= alu.res[ST_Z];
      end else if (apb_st_wr) begin
        z_ff <= PWDATA[ST_Z];
      end
      if (mask[1]) begin
        dc_ff <= alu.dc;                                     // [RL4] [RL6]
      end else if (core_st_wr) begin
        dc_ff <= alu.res[ST_DC];
      end else if (apb_st_wr) begin
        dc_ff <= PWDATA[ST_DC];
      end
      if (mask[0]) begin
        c_ff <= alu.c;                                       // [RL5] [RL6]
      end else if (core_st_wr) begin
        c_ff <= alu.res[ST_C];
      end else if (apb_st_wr) begin
        c_ff <= PWDATA[ST_C];
      end
    end
  end

  // read data is captured in the setup cycle and answered in the access
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rdata_ff <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        ADR_STATUS: rdata_ff <= {24'h000000, STATUS_O};
        ADR_PCL:    rdata_ff <= {24'h000000, pc_ff[7:0]};    // [RL10]
        ADR_PC:     rdata_ff <= {22'h000000, pc_ff};
        ADR_STK1:   rdata_ff <= {20'h00000, stk_ff[0]};
        ADR_STK2:   rdata_ff <= {20'h00000, stk_ff[1]};
        default:    rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign PC_O     = pc_ff;
  assign STATUS_O = {wake_ff, 1'b0, page_ff, to_ff, pd_ff, z_ff, dc_ff, c_ff};
  assign RESULT_O = result_ff;
  assign W_LOAD_O = wload_ff;

endmodule : core_pc_stack_status

// File: core/core_pc_stack_status_pkg.sv
package core_pc_stack_status_pkg;

  localparam int PC_W    = 10;
  localparam int STK_W   = 12;
  localparam int ADDR_W  = 8;

  localparam logic [PC_W-1:0]  PC_RESET_VEC  = 10'h3ff;
  localparam logic [STK_W-1:0] STK_RESET     = 12'h000;

  // status register bit positions
  localparam int ST_WAKE = 7;
  localparam int ST_PAGE = 5;
  localparam int ST_TO   = 4;
  localparam int ST_PD   = 3;
  localparam int ST_Z    = 2;
  localparam int ST_DC   = 1;
  localparam int ST_C    = 0;

  localparam logic ST_WAKE_RST = 1'b0;
  localparam logic ST_PAGE_RST = 1'b0;
  localparam logic ST_TO_RST   = 1'b1;
  localparam logic ST_PD_RST   = 1'b1;
  localparam logic ST_ALU_RST  = 1'b0;

  // apb byte addresses
  localparam logic [ADDR_W-1:0] ADR_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_PCL    = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_PC     = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_STK1   = 8'h0c;
  localparam logic [ADDR_W-1:0] ADR_STK2   = 8'h10;

  typedef enum logic [2:0] {
    OP_NOP    = 3'h0,
    OP_ALU    = 3'h1,
    OP_JUMP   = 3'h2,
    OP_CALL   = 3'h3,
    OP_RETURN_LITERAL_INSTR  = 3'h4,
    OP_WDTCLR = 3'h5,
    OP_SLEEP  = 3'h6
  } op_e;

  typedef enum logic [2:0] {
    ALU_MOVE  = 3'h0,
    ALU_ADD   = 3'h1,
    ALU_SUB   = 3'h2,
    ALU_RRF   = 3'h3,
    ALU_RLF   = 3'h4,
    ALU_LOGIC = 3'h5
  } alu_e;

  typedef struct packed {
    op_e        op;
    alu_e       alu;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [7:0] logic_res;
    logic [8:0] target;
    logic [7:0] lit;
    logic       dest_status;
    logic       dest_pcl;
  } exec_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_s;

  typedef struct packed {
    logic [7:0] res;
    logic       z;
    logic       dc;
    logic       c;
  } alu_out_s;

endpackage : core_pc_stack_status_pkg

// File: tb/core_pc_stack_status_chk.sv
`timescale 1ns/1ns
module core_pc_stack_status_chk
  import core_pc_stack_status_pkg::*;
(
  input wire logic            CLK_I,
  input wire logic            RESET_I,
  input wire logic            EXEC_I,
  input wire exec_s           INSTR_I,
  input wire logic            WDT_TIMEOUT_I,
  input wire logic [PC_W-1:0] PC_O,
  input wire logic [7:0]      STATUS_O,
  input wire byte_s           RESULT_O,
  input wire byte_s           W_LOAD_O
);
  logic [8:0] sum9;
  assign sum9 = {1'b0, INSTR_I.opa} + {1'b0, INSTR_I.opb};
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  chk_reset_vector: assert property ($fell(RESET_I) |-> PC_O == PC_RESET_VEC && STATUS_O == 8'h18)
    else $error("reset state wrong");
  chk_pc_advance: assert property (EXEC_I && INSTR_I.op == OP_NOP |=> PC_O == $past(PC_O) + 10'h001)
    else $error("pc did not advance");
  chk_jump_load: assert property (EXEC_I && INSTR_I.op == OP_JUMP
    |=> PC_O == {$past(STATUS_O[ST_PAGE]), $past(INSTR_I.target)}) else $error("jump target wrong");
  chk_call_load: assert property (EXEC_I && INSTR_I.op == OP_CALL
    |=> PC_O[8:0] == {1'b0, $past(INSTR_I.lit)}) else $error("call target wrong");
  chk_sleep_flags: assert property (EXEC_I && INSTR_I.op == OP_SLEEP
    |=> STATUS_O[ST_TO] && !STATUS_O[ST_PD]) else $error("sleep flags wrong");
  chk_clear_flags: assert property (EXEC_I && INSTR_I.op == OP_WDTCLR
    |=> STATUS_O[ST_TO] && STATUS_O[ST_PD]) else $error("clear flags wrong");
  chk_timeout_clear: assert property (WDT_TIMEOUT_I && !EXEC_I |=> !STATUS_O[ST_TO])
    else $error("time-out flag not cleared");
  chk_return_literal_instr_w: assert property (EXEC_I && INSTR_I.op == OP_RETURN_LITERAL_INSTR
    |=> W_LOAD_O.valid && W_LOAD_O.data == $past(INSTR_I.lit)) else $error("w literal wrong");
  chk_add_carry: assert property (EXEC_I && INSTR_I.op == OP_ALU && INSTR_I.alu == ALU_ADD
    && !INSTR_I.dest_status |=> {STATUS_O[ST_C], RESULT_O.data} == $past(sum9))
    else $error("add carry wrong");
endmodule : core_pc_stack_status_chk

bind core_pc_stack_status core_pc_stack_status_chk u_chk (.CLK_I, .RESET_I, .EXEC_I, .INSTR_I,
  .WDT_TIMEOUT_I, .PC_O, .STATUS_O, .RESULT_O, .W_LOAD_O);

// File: tb/fetch_model.sv
`timescale 1ns/1ns
module fetch_model
  import core_pc_stack_status_pkg::*;
(
  input  wire logic clk_i,
  output logic      exec_o,
  output exec_s     instr_o
);
  initial begin
    exec_o = 1'b0;
    instr_o = '0;
  end
  // idle word is the inverse of the last one so stale fields never match the issued word
  task issue(input exec_s i);
    @(posedge clk_i);
    exec_o <= 1'b1;
    instr_o <= i;
    @(posedge clk_i);
    exec_o <= 1'b0;
    instr_o <= exec_s'(~i);
  endtask : issue
endmodule : fetch_model

// File: tb/core_pc_stack_status_tb.sv
`timescale 1ns/1ns
module core_pc_stack_status_tb;
  import core_pc_stack_status_pkg::*;
  logic clk = 0, rst = 1, wto = 0, psel = 0, pen = 0, pwr = 0, zf = 0, dcf = 0, cf = 0;
  logic [7:0] pa = 0;
  logic [31:0] pwd = 0, seed = 25, prd;
  logic [PC_W-1:0] pc;
  logic [7:0] st;
  logic exe, rdy, err;
  exec_s ins;
  byte_s res, wl;
  alu_e k;
  logic [32:0] exq[$];
  int n_errors = 0, num_checks = 0, cyc = 0;

  initial forever #2 clk = ~clk;

  core_pc_stack_status DUT (.CLK_I(clk), .RESET_I(rst), .EXEC_I(exe), .INSTR_I(ins),
    .WDT_TIMEOUT_I(wto), .PC_O(pc), .STATUS_O(st), .RESULT_O(res), .W_LOAD_O(wl),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(rdy), .PSLVERR(err));
  fetch_model fm (.clk_i(clk), .exec_o(exe), .instr_o(ins));

  function logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task chk(input string nm, input logic [32:0] e, input logic [32:0] s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  task tally_and_finish();
    if (exq.size() != 0) n_errors++;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    if (res.valid === 1'b1) chk("alu", exq.pop_front(), {22'h0, st[2:0], res.data});
    if (wl.valid === 1'b1) chk("wload", exq.pop_front(), {25'h0, wl.data});
    if (psel && pen && rdy && !pwr) chk("prdata", exq.pop_front(), {err, prd});
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    psel <= 0;
    pen <= 0;
  endtask : apb

  task rd(input logic [7:0] a, input logic [32:0] e);
    exq.push_back(e);
    apb(0, a, 0);
  endtask : rd

  task ex(input op_e o, input logic [7:0] a, b, l, input logic [8:0] t, input alu_e q,
          input logic ds = 1'b0, input logic dp = 1'b0);
    exec_s i;
    i = '{o, q, a, b, a & b, t, l, ds, dp};
    fm.issue(i);
  endtask : ex

  task alu(input alu_e q, input logic [7:0] a, b, input logic ds = 1'b0,
           input logic dp = 1'b0);
    logic [8:0] s;
    logic [7:0] r;
    case (q)
      ALU_ADD: begin
        s = a + b;
        r = s[7:0];
        cf = s[8];
        dcf = (a[3:0] + b[3:0]) > 5'h0f;
      end
      ALU_SUB: begin
        r = a - b;
        cf = a >= b;
        dcf = a[3:0] >= b[3:0];
      end
      ALU_RRF: begin
        r = {cf, a[7:1]};
        cf = a[0];
      end
      ALU_RLF: begin
        r = {a[6:0], cf};
        cf = a[7];
      end
      ALU_MOVE: r = a;
      default: r = a & b;
    endcase
    // rotates and moves leave the zero flag alone
    if (q inside {ALU_ADD, ALU_SUB, ALU_LOGIC}) zf = r == 8'h00;
    exq.push_back({22'h0, zf, dcf, cf, r});
    ex(OP_ALU, a, b, 0, 0, q, ds, dp);
  endtask : alu

  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    rd(ADR_STATUS, 33'h18);
    rd(ADR_PC, 33'h3ff);
    rd(8'h14, 33'h100000000);
    ex(OP_NOP, 0, 0, 0, 0, ALU_MOVE);
    rd(ADR_PC, 33'h0);
    apb(1, ADR_STATUS, 32'h20);
    rd(ADR_STATUS, 33'h38);
    ex(OP_JUMP, 0, 0, 0, 9'h1a5, ALU_MOVE);
    rd(ADR_PC, 33'h3a5);
    ex(OP_CALL, 0, 0, 8'h42, 0, ALU_MOVE);
    rd(ADR_PC, 33'h242);
    rd(ADR_STK1, 33'h3a6);
    ex(OP_CALL, 0, 0, 8'h10, 0, ALU_MOVE);
    ex(OP_CALL, 0, 0, 8'h20, 0, ALU_MOVE);
    rd(ADR_STK1, 33'h211);
    rd(ADR_STK2, 33'h243);
    // three returns from two levels: level two is replayed, no fault reported
    foreach (seed[i]) if (i < 3) begin
      exq.push_back(33'h5a + i);
      ex(OP_RETURN_LITERAL_INSTR, 0, 0, 8'h5a + 8'(i), 0, ALU_MOVE);
    end
    rd(ADR_PC, 33'h243);
    rd(ADR_STK1, 33'h243);
    apb(1, ADR_PC, 32'h0);
    rd(ADR_PC, 33'h243);
    apb(1, ADR_PCL, 32'h80);
    rd(ADR_PC, 33'h280);
    rd(ADR_PCL, 33'h80);
    alu(ALU_SUB, 8'h35, 8'h35);
    repeat (24) begin
      seed = xs(seed);
      k = alu_e'(3'(seed[10:8] % 3'h5) + 3'h1);
      alu(k, seed[7:0], seed[23:16]);
    end
    ex(OP_SLEEP, 0, 0, 0, 0, ALU_MOVE);
    rd(ADR_STATUS, {25'h0, 5'b00110, zf, dcf, cf});
    @(posedge clk);
    wto <= 1;
    @(posedge clk);
    wto <= 0;
    rd(ADR_STATUS, {25'h0, 5'b00100, zf, dcf, cf});
    ex(OP_WDTCLR, 0, 0, 0, 0, ALU_MOVE);
    rd(ADR_STATUS, {25'h0, 5'b00111, zf, dcf, cf});
    alu(ALU_MOVE, 8'h00, 8'h55);
    alu(ALU_ADD, 8'h30, 8'h10, 1'b0, 1'b1);
    rd(ADR_PC, 33'h240);
    alu(ALU_ADD, 8'h80, 8'h80, 1'b1, 1'b0);
    rd(ADR_STATUS, 33'h1d);
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule : core_pc_stack_status_tb
